// File: hdl/twns_pkg.sv
package twns_pkg;
	localparam int AW = 13;
	localparam int DW = 8;
	localparam int HI_BITS = AW - 8;
	// device-type code, arbitrary value
	localparam logic [3:0] DEV_ID = 4'h5;
	localparam int ID_MSB = 7;
	localparam int ID_LSB = 4;
	localparam int SEL_MSB = 2;
	localparam int SEL_LSB = 1;
	localparam int RW_BIT = 0;
	localparam logic [1:0] PROT_TOP = 2'h3;
	localparam logic [AW-1:0] ADDR_TOP = 13'h1fff;
	localparam logic [AW-1:0] ADDR_ONE = 13'h0001;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_ACK = 4'h9;
	localparam logic [3:0] BIT_FIRST = 4'h1;
	localparam logic [3:0] BIT_SEVEN = 4'h7;
	localparam int CLK_MHZ = 50;
	localparam int RESTORE_NS = 8000;
	localparam int RESTORE_CYC = (RESTORE_NS * CLK_MHZ + 999) / 1000;
	localparam int RCW = 16;
	localparam int SYNC_L = 7;
	localparam int SYNC_M = 3;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_DEV = 7'h02,
		ST_AHI = 7'h04,
		ST_ALO = 7'h08,
		ST_WR = 7'h10,
		ST_RD = 7'h20,
		ST_WAIT = 7'h40
	} twns_state_e;
	function automatic logic prot_hit(input logic wp, input logic [AW-1:0] a);
		return wp && (a[AW-1:AW-2] == PROT_TOP);
	endfunction : prot_hit
endpackage : twns_pkg

// File: hdl/twns_mem.sv
`timescale 1ns/1ps
module twns_mem #(
	parameter int AW = twns_pkg::AW,
	parameter int DW = twns_pkg::DW
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule : twns_mem

// File: hdl/twns_slave.sv
`timescale 1ns/1ps
module twns_slave #(
	parameter int RESTORE_CYC = twns_pkg::RESTORE_CYC
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic lclk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic wp_i,
	input wire logic [1:0] device_select_straps_i,
	input wire logic power_fail_i,
	input wire logic save_done_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic restore_busy_o,
	output logic save_pending_o,
	output logic save_start_o
);
	localparam int AW = twns_pkg::AW;
	localparam int DW = twns_pkg::DW;

	// link-domain synchronisers
	logic [twns_pkg::SYNC_L-1:0] ls1_r, ls2_r;
	logic restore_busy_r;
	always_ff @(posedge lclk_i) begin
		ls1_r <= {nrst_i, restore_busy_r, scl_i, sda_i, wp_i, device_select_straps_i};
		ls2_r <= ls1_r;
	end
	logic lrst_n, busy_l, scl_s, sda_s, wp_s;
	logic [1:0] straps_s;
	assign {lrst_n, busy_l, scl_s, sda_s, wp_s, straps_s} = ls2_r;

	twns_pkg::twns_state_e state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [DW-1:0] sr_r, sr_nxt, tx_r, tx_nxt, stg_d_r, stg_d_nxt;
	logic [AW-1:0] addr_r, addr_nxt, stg_a_r, stg_a_nxt;
	logic [twns_pkg::HI_BITS-1:0] ahi_r, ahi_nxt;
	logic oe_r, oe_nxt, stg_v_r, stg_v_nxt, wrote_r, wrote_nxt, ctg_r, ctg_nxt;
	logic scl_d_r, sda_d_r, we;
	logic [DW-1:0] rdata;
	logic rise, fall, start, stop, match, prot;

	// edges from synchronised samples only
	assign rise = scl_s && !scl_d_r;
	assign fall = !scl_s && scl_d_r;
	assign start = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop = scl_s && scl_d_r && !sda_d_r && sda_s;
	assign match = (sr_r[twns_pkg::ID_MSB:twns_pkg::ID_LSB] == twns_pkg::DEV_ID)
		&& (sr_r[twns_pkg::SEL_MSB:twns_pkg::SEL_LSB] == straps_s);
	assign prot = twns_pkg::prot_hit(wp_s, addr_r);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sr_nxt = sr_r;
		tx_nxt = tx_r;
		oe_nxt = oe_r;
		addr_nxt = addr_r;
		ahi_nxt = ahi_r;
		stg_v_nxt = stg_v_r;
		stg_a_nxt = stg_a_r;
		stg_d_nxt = stg_d_r;
		wrote_nxt = wrote_r;
		ctg_nxt = ctg_r;
		we = 1'b0;
		if (busy_l) begin
			// bus ignored during restore
			state_nxt = twns_pkg::ST_IDLE;
			oe_nxt = 1'b0;
			cnt_nxt = '0;
			stg_v_nxt = 1'b0;
			wrote_nxt = 1'b0;
		end else if (stop) begin
			// stop commits staged byte and flags save if any byte was written
			state_nxt = twns_pkg::ST_IDLE;
			oe_nxt = 1'b0;
			cnt_nxt = '0;
			we = stg_v_r;
			if (stg_v_r || wrote_r) begin
				ctg_nxt = !ctg_r;
			end
			stg_v_nxt = 1'b0;
			wrote_nxt = 1'b0;
		end else if (start) begin
			// start aborts and discards the staged byte
			state_nxt = twns_pkg::ST_DEV;
			oe_nxt = 1'b0;
			cnt_nxt = '0;
			stg_v_nxt = 1'b0;
			wrote_nxt = 1'b0;
		end else if (state_r != twns_pkg::ST_IDLE && state_r != twns_pkg::ST_WAIT) begin
			if (rise) begin
				// msb-first shift on rising edge
				sr_nxt = {sr_r[DW-2:0], sda_s};
				cnt_nxt = cnt_r + 4'h1;
			end
			if (fall) begin
				if (cnt_r >= twns_pkg::BIT_FIRST && cnt_r <= twns_pkg::BIT_SEVEN) begin
					if (state_r == twns_pkg::ST_RD) begin
						// next read bit on falling edge, drive only lows
						tx_nxt = {tx_r[DW-2:0], 1'b1};
						oe_nxt = !tx_r[DW-2];
					end
				end else if (cnt_r == twns_pkg::BIT_LAST) begin
					oe_nxt = 1'b1;
					unique case (state_r)
						twns_pkg::ST_DEV: begin
							if (!match) begin
								state_nxt = twns_pkg::ST_WAIT;
								oe_nxt = 1'b0;
							end else if (sr_r[twns_pkg::RW_BIT]) begin
								state_nxt = twns_pkg::ST_RD;
							end else begin
								state_nxt = twns_pkg::ST_AHI;
							end
						end
						twns_pkg::ST_AHI: begin
							ahi_nxt = sr_r[twns_pkg::HI_BITS-1:0];
							state_nxt = twns_pkg::ST_ALO;
						end
						twns_pkg::ST_ALO: begin
							addr_nxt = {ahi_r, sr_r};
							state_nxt = twns_pkg::ST_WR;
						end
						twns_pkg::ST_WR: begin
							// previous byte written, new byte staged unless protected
							we = stg_v_r;
							wrote_nxt = wrote_r || stg_v_r;
							stg_a_nxt = addr_r;
							stg_d_nxt = sr_r;
							stg_v_nxt = !prot;
							if (!prot) begin
								addr_nxt = addr_r + twns_pkg::ADDR_ONE;
							end
						end
						twns_pkg::ST_RD: begin
							oe_nxt = 1'b0;
							addr_nxt = addr_r + twns_pkg::ADDR_ONE;
						end
						default: begin
							oe_nxt = 1'b0;
						end
					endcase
				end else if (cnt_r == twns_pkg::BIT_ACK) begin
					cnt_nxt = '0;
					oe_nxt = 1'b0;
					if (state_r == twns_pkg::ST_RD) begin
						if (sr_r[0]) begin
							state_nxt = twns_pkg::ST_WAIT;
						end else begin
							tx_nxt = rdata;
							oe_nxt = !rdata[DW-1];
						end
					end
				end
			end
		end
	end

	always_ff @(posedge lclk_i) begin
		if (!lrst_n) begin
			state_r <= twns_pkg::ST_IDLE;
			cnt_r <= '0;
			sr_r <= '0;
			tx_r <= '0;
			oe_r <= 1'b0;
			addr_r <= '0;
			ahi_r <= '0;
			stg_v_r <= 1'b0;
			stg_a_r <= '0;
			stg_d_r <= '0;
			wrote_r <= 1'b0;
			ctg_r <= 1'b0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			sr_r <= sr_nxt;
			tx_r <= tx_nxt;
			oe_r <= oe_nxt;
			addr_r <= addr_nxt;
			ahi_r <= ahi_nxt;
			stg_v_r <= stg_v_nxt;
			stg_a_r <= stg_a_nxt;
			stg_d_r <= stg_d_nxt;
			wrote_r <= wrote_nxt;
			ctg_r <= ctg_nxt;
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			sda_o <= 1'b0;
			sda_oe_o <= oe_nxt;
		end
	end

	twns_mem #(
		.AW(AW),
		.DW(DW)
	) u_mem (
		.clk_i(lclk_i),
		.we_i(we),
		.waddr_i(stg_a_r),
		.wdata_i(stg_d_r),
		.raddr_i(addr_r),
		.rdata_o(rdata)
	);

	// main-clock side: restore timer, save bookkeeping
	logic [twns_pkg::SYNC_M-1:0] ms1_r, ms2_r, ms3_r;
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			ms1_r <= '0;
			ms2_r <= '0;
		end else begin
			ms1_r <= {power_fail_i, save_done_i, ctg_r};
			ms2_r <= ms1_r;
		end
	end
	logic [twns_pkg::RCW-1:0] rcnt_r, rcnt_nxt;
	logic busy_nxt, pend_r, pend_nxt, sst_nxt, pf_ev, done_ev, commit_ev;
	assign pf_ev = ms2_r[2] && !ms3_r[2];
	assign done_ev = ms2_r[1] && !ms3_r[1];
	assign commit_ev = ms2_r[0] != ms3_r[0];
	always_comb begin
		rcnt_nxt = rcnt_r;
		busy_nxt = restore_busy_r;
		if (restore_busy_r) begin
			rcnt_nxt = rcnt_r + 16'h0001;
			if (rcnt_r == twns_pkg::RCW'(RESTORE_CYC - 1)) begin
				busy_nxt = 1'b0;
			end
		end
		pend_nxt = commit_ev || (pend_r && !done_ev);
		sst_nxt = pf_ev && pend_r;
	end
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			rcnt_r <= '0;
			restore_busy_r <= 1'b1;
			pend_r <= 1'b0;
			ms3_r <= '0;
			restore_busy_o <= 1'b1;
			save_pending_o <= 1'b0;
			save_start_o <= 1'b0;
		end else begin
			rcnt_r <= rcnt_nxt;
			restore_busy_r <= busy_nxt;
			pend_r <= pend_nxt;
			ms3_r <= ms2_r;
			restore_busy_o <= busy_nxt;
			save_pending_o <= pend_nxt;
			save_start_o <= sst_nxt;
		end
	end
	property p_stop_idle;
		@(posedge lclk_i) disable iff (!lrst_n)
		stop && !busy_l |=> state_r == twns_pkg::ST_IDLE && !sda_oe_o;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");
	property p_start_dev;
		@(posedge lclk_i) disable iff (!lrst_n)
		start && !busy_l |=> state_r == twns_pkg::ST_DEV && cnt_r == 4'h0 && !stg_v_r;
	endproperty
	a_start_dev: assert property (p_start_dev) else $error("start did not restart");
	property p_restore_quiet;
		@(posedge lclk_i) disable iff (!lrst_n)
		busy_l |=> !sda_oe_o && state_r == twns_pkg::ST_IDLE;
	endproperty
	a_restore_quiet: assert property (p_restore_quiet) else $error("bus active in restore");
	property p_addr_ack;
		@(posedge lclk_i) disable iff (!lrst_n)
		fall && !start && !stop && !busy_l && cnt_r == twns_pkg::BIT_LAST
			&& (state_r == twns_pkg::ST_AHI || state_r == twns_pkg::ST_ALO)
			|=> sda_oe_o;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address byte not acked");
	property p_nomatch;
		@(posedge lclk_i) disable iff (!lrst_n)
		fall && !start && !stop && !busy_l && cnt_r == twns_pkg::BIT_LAST
			&& state_r == twns_pkg::ST_DEV && !match
			|=> state_r == twns_pkg::ST_WAIT && !sda_oe_o;
	endproperty
	a_nomatch: assert property (p_nomatch) else $error("mismatch answered");
	property p_nack_end;
		@(posedge lclk_i) disable iff (!lrst_n)
		fall && !start && !stop && !busy_l && cnt_r == twns_pkg::BIT_ACK
			&& state_r == twns_pkg::ST_RD && sr_r[0]
			|=> state_r == twns_pkg::ST_WAIT;
	endproperty
	a_nack_end: assert property (p_nack_end) else $error("read went on after nack");
	property p_wr_advance;
		@(posedge lclk_i) disable iff (!lrst_n)
		fall && !start && !stop && !busy_l && cnt_r == twns_pkg::BIT_LAST
			&& state_r == twns_pkg::ST_WR
			|=> addr_r == ($past(prot) ? $past(addr_r) : $past(addr_r) + twns_pkg::ADDR_ONE);
	endproperty
	a_wr_advance: assert property (p_wr_advance) else $error("write address step wrong");
	property p_pending;
		@(posedge mclk_i) disable iff (!nrst_i)
		commit_ev |=> save_pending_o;
	endproperty
	a_pending: assert property (p_pending) else $error("pending not set");
	property p_save_skip;
		@(posedge mclk_i) disable iff (!nrst_i)
		pf_ev && !pend_r |=> !save_start_o;
	endproperty
	a_save_skip: assert property (p_save_skip) else $error("needless save");
endmodule : twns_slave

// File: testbench/twns_master.sv
`timescale 1ns/1ps
module twns_master (
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic qp;
		repeat (5) @(posedge mclk_i);
		#1;
	endtask : qp
	// nine clocks: data set in the low phase, msb first, sampled late in the high phase
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			qp();
			sda_low_o = ~d[i];
			qp();
			scl_o = 1'b1;
			qp();
			qp();
			r[i] = sda_i;
			scl_o = 1'b0;
		end
	endtask : xfer
	// start or repeated start, also after a dummy write
	task automatic start;
		qp();
		sda_low_o = 1'b0;
		qp();
		scl_o = 1'b1;
		qp();
		sda_low_o = 1'b1;
		qp();
		scl_o = 1'b0;
	endtask : start
	// stop only while the master holds the line
	task automatic stop;
		qp();
		sda_low_o = 1'b1;
		qp();
		scl_o = 1'b1;
		qp();
		sda_low_o = 1'b0;
		qp();
	endtask : stop
endmodule : twns_master

// File: testbench/tb_two_wire_nvsram_slave.sv
`timescale 1ns/1ps
module tb_two_wire_nvsram_slave;
	localparam logic [1:0] SEL = 2'h2;
	localparam logic [7:0] SW = {twns_pkg::DEV_ID, 1'b0, SEL, 1'b0};
	localparam logic [7:0] SR = SW | 8'h01;
	logic mclk_i = 1'b0;
	logic lclk = 1'b0;
	logic nrst_i = 1'b0;
	logic wp = 1'b0;
	logic pf = 1'b0;
	logic sdone = 1'b0;
	logic [1:0] straps = SEL;
	logic scl, m_low, sda_o, sda_oe, busy, pend, sstart, seen;
	logic [8:0] r;
	int errors = 0;
	int total_checks = 0;
	wire logic sda = (m_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;
	always #10 mclk_i = ~mclk_i;
	initial begin
		#3;
		forever #6 lclk = ~lclk;
	end
	twns_slave #(.RESTORE_CYC(10)) twns_slave_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.lclk_i(lclk), .scl_i(scl), .sda_i(sda), .wp_i(wp), .device_select_straps_i(straps),
		.power_fail_i(pf), .save_done_i(sdone), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.restore_busy_o(busy), .save_pending_o(pend), .save_start_o(sstart));
	twns_master twns_master_inst (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
	task automatic summarize;
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic sb(input logic [7:0] b, input logic ea);
		twns_master_inst.xfer({b, 1'b1}, r);
		chk("ack", {7'h00, r[0]}, {7'h00, ea});
	endtask : sb
	task automatic addr(input logic [12:0] a);
		twns_master_inst.start();
		sb(SW, 1'b0);
		sb({3'h7, a[12:8]}, 1'b0);
		sb(a[7:0], 1'b0);
	endtask : addr
	task automatic rd(input logic [7:0] e, input logic ack);
		twns_master_inst.xfer({8'hff, ack}, r);
		chk("rdata", r[8:1], e);
	endtask : rd
	task automatic pwr;
		#1;
		sdone = 1'b0;
		seen = 1'b0;
		pf = 1'b1;
		repeat (20) begin
			@(posedge mclk_i);
			seen = seen | (sstart === 1'b1);
		end
		#1;
		pf = 1'b0;
	endtask : pwr
	initial begin
		#1000000;
		errors++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge mclk_i);
		chk("busy", {7'h00, busy}, 8'h01);
		chk("oe", {7'h00, sda_oe}, 8'h00);
		chk("sda_o", {7'h00, sda_o}, 8'h00);
		#1;
		nrst_i = 1'b1;
		repeat (5) @(posedge mclk_i);
		chk("busy", {7'h00, busy}, 8'h01);
		repeat (15) @(posedge mclk_i);
		chk("busy", {7'h00, busy}, 8'h00);
		addr(13'h1fff);
		sb(8'ha5, 1'b0);
		sb(8'h3c, 1'b0);
		sb(8'h5a, 1'b0);
		twns_master_inst.stop();
		repeat (20) @(posedge mclk_i);
		chk("pend", {7'h00, pend}, 8'h01);
		pwr();
		chk("save", {7'h00, seen}, 8'h01);
		sdone = 1'b1;
		repeat (10) @(posedge mclk_i);
		chk("pend", {7'h00, pend}, 8'h00);
		pwr();
		chk("save", {7'h00, seen}, 8'h00);
		addr(13'h1fff);
		twns_master_inst.start();
		sb(SR, 1'b0);
		rd(8'ha5, 1'b0);
		rd(8'h3c, 1'b0);
		twns_master_inst.xfer(9'h1ff, r);
		chk("nack", {7'h00, r[0]}, 8'h01);
		twns_master_inst.start();
		sb(SW, 1'b0);
		twns_master_inst.stop();
		twns_master_inst.start();
		sb({twns_pkg::DEV_ID, 1'b0, ~SEL, 1'b0}, 1'b1);
		sb(8'h00, 1'b1);
		twns_master_inst.start();
		sb({twns_pkg::DEV_ID ^ 4'h1, 1'b0, SEL, 1'b0}, 1'b1);
		twns_master_inst.stop();
		straps = ~SEL;
		twns_master_inst.start();
		sb({twns_pkg::DEV_ID, 1'b0, ~SEL, 1'b0}, 1'b0);
		twns_master_inst.stop();
		straps = SEL;
		addr(13'h0100);
		sb(8'h33, 1'b0);
		twns_master_inst.stop();
		addr(13'h0100);
		sb(8'h44, 1'b0);
		addr(13'h0100);
		twns_master_inst.start();
		sb(SR, 1'b0);
		rd(8'h33, 1'b1);
		twns_master_inst.stop();
		addr(13'h1800);
		sb(8'h11, 1'b0);
		twns_master_inst.stop();
		wp = 1'b1;
		addr(13'h1800);
		sb(8'h77, 1'b0);
		twns_master_inst.stop();
		twns_master_inst.start();
		sb(SR, 1'b0);
		rd(8'h11, 1'b1);
		twns_master_inst.stop();
		wp = 1'b0;
		summarize();
	end
endmodule : tb_two_wire_nvsram_slave
